// File: design/acspi_top.sv
// How it works
// RULE1 - transaction spans select low; device idle while select high
// RULE2 - all words msb first, lsb last
// RULE3 - miso changes on sck falling edges
// RULE4 - mosi captured on sck rising edges
// RULE5 - first eight bits after select falls form the command
// RULE6 - select rising clears bit counter and command register
// RULE7 - unknown command: ignore further input, miso undriven until reselect
// RULE8 - master sends write data straight after the command
// RULE9 - first response bit driven on falling edge after last command bit
// RULE10 - output bits shift out alongside incoming data bits
// RULE11 - master keeps sck at or below 500 kHz
// RULE12 - master reads each axis at most 5300 times per second
// RULE13 - mode commands: run 00, self test x 0E, y 0F
// RULE14 - read commands: temperature 08, x 10, y 11
// RULE15 - run mode after reset; run command ends self test
// RULE16 - 8-bit temperature register refreshed every 150 us, read msb first
// RULE17 - data registers not reloaded while select is low; code can still reload within two reference cycles after select falls
// RULE18 - master holds select high 150 us before a data read
// RULE19 - bits shifted in during temperature read are ignored
// RULE20 - self test drives the chosen channel's charge pump
// RULE21 - master never enables both self tests together
// RULE22 - 11-bit acceleration registers reloaded every 150 us
// RULE23 - miso undriven when deselected, driven only for read responses
`timescale 1ns/1ps
`include "acspi_cfg.svh"
module acspi_top
#(
	parameter int RELOAD_CYC = `ACSPI_RELOAD_CYC
)
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic sck_i,
	input wire logic select_n_line_i,
	input wire logic mosi_i,
	input wire logic [10:0] adc_x_i,
	input wire logic [10:0] adc_y_i,
	input wire logic [7:0] adc_temp_i,
	output logic miso_o,
	output logic miso_oe_o,
	output logic pump_x_o,
	output logic pump_y_o
);
	acspi_link_if lk();

	acspi_serial u_serial
	(
		.rst_i(rst_i),
		.sck_i(sck_i),
		.select_n_line_i(select_n_line_i),
		.mosi_i(mosi_i),
		.miso_o(miso_o),
		.miso_oe_o(miso_oe_o),
		.lk(lk.link)
	);

	////////////////////////////////////////////////////////////////////////
	// synchronisers for pin level and command toggle
	logic sel_m;
	logic sel_s;
	logic tg_m;
	logic tg_s;
	logic tg_d;
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sel_m <= 1'b1;
			sel_s <= 1'b1;
			tg_m <= 1'b0;
			tg_s <= 1'b0;
			tg_d <= 1'b0;
		end
		else
		begin
			sel_m <= select_n_line_i;
			sel_s <= sel_m;
			tg_m <= lk.cmd_tgl;
			tg_s <= tg_m;
			tg_d <= tg_s;
		end
	end
	// code is stable long before the toggle arrives (held until next mode command)
	wire cmd_evt = tg_s ^ tg_d;

	////////////////////////////////////////////////////////////////////////
	// mode register
	acspi_pkg::acspi_mode_t mode;
	acspi_pkg::acspi_mode_t next_mode;
	always_comb
	begin
		next_mode = mode;
		if (cmd_evt)
		begin
			case (lk.cmd_code)
				`ACSPI_NORMAL_RUN_CMD: next_mode = acspi_pkg::ACSPI_MODE_RUN; // RULE15
				`ACSPI_SELFTEST_X_CMD: next_mode = acspi_pkg::ACSPI_MODE_STX; // RULE13
				`ACSPI_SELFTEST_Y_CMD: next_mode = acspi_pkg::ACSPI_MODE_STY; // RULE13
				default: next_mode = mode;
			endcase
		end
	end
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			mode <= acspi_pkg::ACSPI_MODE_RUN; // RULE15
		else
			mode <= next_mode;
	end
	assign pump_x_o = mode == acspi_pkg::ACSPI_MODE_STX; // RULE20
	assign pump_y_o = mode == acspi_pkg::ACSPI_MODE_STY; // RULE20

	////////////////////////////////////////////////////////////////////////
	// reload timer; registers only load while the synchronised select is high
	logic [15:0] tick;
	wire tick_end = tick == 16'(RELOAD_CYC - 1);
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			tick <= 16'h0000;
		else if (tick_end)
			tick <= 16'h0000;
		else
			tick <= tick + 16'h0001;
	end
	// gate on the synchronised select; a conversion landing within two reference cycles
	// after select falls still loads, since sel_s lags the pin
	wire do_load = tick_end && sel_s; // RULE17
	logic [10:0] acc_x;
	logic [10:0] acc_y;
	logic [7:0] temp;
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			acc_x <= `ACSPI_ACC_RST;
			acc_y <= `ACSPI_ACC_RST;
			temp <= `ACSPI_TEMP_RST;
		end
		else if (do_load)
		begin
			acc_x <= adc_x_i; // RULE22
			acc_y <= adc_y_i; // RULE22
			temp <= adc_temp_i; // RULE16
		end
	end
	assign lk.acc_x = acc_x;
	assign lk.acc_y = acc_y;
	assign lk.temp = temp;
endmodule : acspi_top

// File: design/acspi_cfg.svh
// timing counts, command codes and widths for the accelerometer spi command port
`ifndef ACSPI_CFG_SVH
`define ACSPI_CFG_SVH
`define ACSPI_REF_CLK_KHZ 10000
`define ACSPI_RELOAD_US 150
`define ACSPI_RELOAD_CYC ((`ACSPI_RELOAD_US * `ACSPI_REF_CLK_KHZ) / 1000)
`define ACSPI_CMD_W 8
`define ACSPI_ACC_W 11
`define ACSPI_TEMP_W 8
`define ACSPI_NORMAL_RUN_CMD 8'h00
`define ACSPI_READ_TEMPERATURE_CMD 8'h08
`define ACSPI_SELFTEST_X_CMD 8'h0E
`define ACSPI_SELFTEST_Y_CMD 8'h0F
`define ACSPI_READ_ACCEL_X_CMD 8'h10
`define ACSPI_READ_ACCEL_Y_CMD 8'h11
`define ACSPI_TEMP_RST 8'h00
`define ACSPI_ACC_RST 11'h000
`endif

// File: design/acspi_pkg.sv
// types shared by the accelerometer spi command port
package acspi_pkg;
	typedef enum logic [1:0]
	{
		ACSPI_MODE_RUN = 2'b00,
		ACSPI_MODE_STX = 2'b01,
		ACSPI_MODE_STY = 2'b10
	} acspi_mode_t;
	typedef enum logic [1:0]
	{
		ACSPI_PH_CMD = 2'b00,
		ACSPI_PH_DATA = 2'b01,
		ACSPI_PH_DEAD = 2'b10
	} acspi_phase_t;
endpackage : acspi_pkg

// File: design/acspi_link_if.sv
// signals between the serial link end and the reference clock core
`timescale 1ns/1ps
interface acspi_link_if;
	logic [10:0] acc_x;
	logic [10:0] acc_y;
	logic [7:0] temp;
	logic cmd_tgl;
	logic [7:0] cmd_code;
	modport link
	(
		input acc_x,
		input acc_y,
		input temp,
		output cmd_tgl,
		output cmd_code
	);
	modport core
	(
		output acc_x,
		output acc_y,
		output temp,
		input cmd_tgl,
		input cmd_code
	);
endinterface : acspi_link_if

// File: design/acspi_serial.sv
// serial shifter running on the master's clock
`timescale 1ns/1ps
`include "acspi_cfg.svh"
module acspi_serial
(
	input wire logic rst_i,
	input wire logic sck_i,
	input wire logic select_n_line_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_o,
	acspi_link_if.link lk
);
	acspi_pkg::acspi_phase_t phase;
	logic [3:0] bit_cnt;
	logic [7:0] cmd_sr;
	logic [10:0] out_sr;
	logic tgl;
	logic [7:0] code;
	logic drive;
	logic miso;
	wire [7:0] cmd_full = {cmd_sr[6:0], mosi_i};
	wire last_cmd_bit = (phase == acspi_pkg::ACSPI_PH_CMD) && (bit_cnt == 4'h7);
	wire is_mode = (cmd_full == `ACSPI_NORMAL_RUN_CMD) || (cmd_full == `ACSPI_SELFTEST_X_CMD)
		|| (cmd_full == `ACSPI_SELFTEST_Y_CMD);
	wire is_rdx = cmd_full == `ACSPI_READ_ACCEL_X_CMD;
	wire is_rdy = cmd_full == `ACSPI_READ_ACCEL_Y_CMD;
	wire is_rdt = cmd_full == `ACSPI_READ_TEMPERATURE_CMD;
	wire is_read = is_rdx || is_rdy || is_rdt; // RULE14
	// data registers frozen while sel_s is low, so sampling them here is stable
	wire [10:0] load_word = is_rdx ? lk.acc_x :
		is_rdy ? lk.acc_y : {lk.temp, 3'h0};

	////////////////////////////////////////////////////////////////////////
	// rising edge: capture; select high clears counter and command
	always_ff @(posedge sck_i or posedge select_n_line_i)
	begin
		if (select_n_line_i)
		begin
			phase <= acspi_pkg::ACSPI_PH_CMD; // RULE1
			bit_cnt <= 4'h0; // RULE6
			cmd_sr <= 8'h00; // RULE6
		end
		else if (phase == acspi_pkg::ACSPI_PH_CMD)
		begin
			cmd_sr <= cmd_full; // RULE4
			bit_cnt <= bit_cnt + 4'h1;
			if (last_cmd_bit) // RULE5
			begin
				phase <= (is_mode || is_read) ? acspi_pkg::ACSPI_PH_DATA :
					acspi_pkg::ACSPI_PH_DEAD; // RULE7
			end
		end
	end

	// load response word at the command's last rising edge; indexed msb first below
	always_ff @(posedge sck_i or posedge select_n_line_i)
	begin
		if (select_n_line_i)
		begin
			out_sr <= `ACSPI_ACC_RST;
			drive <= 1'b0;
		end
		else if (last_cmd_bit)
		begin
			out_sr <= load_word;
			drive <= is_read; // RULE23
		end
	end

	// command event toward core; persists across select so the toggle survives
	// core reset clears it; sck stands idle while reset is held
	always_ff @(posedge sck_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			tgl <= 1'b0;
			code <= 8'h00;
		end
		else if (last_cmd_bit && is_mode)
		begin
			tgl <= ~tgl;
			code <= cmd_full;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// falling edge: shift out msb first, first bit right after the command
	logic [3:0] out_idx;
	always_ff @(negedge sck_i or posedge select_n_line_i)
	begin
		if (select_n_line_i)
		begin
			out_idx <= 4'h0;
			miso <= 1'b0;
		end
		else if (drive && (phase == acspi_pkg::ACSPI_PH_DATA))
		begin
			miso <= out_sr[4'hA - out_idx]; // RULE2 RULE3 RULE9 RULE10
			if (out_idx != 4'hA)
				out_idx <= out_idx + 4'h1;
		end
	end
	logic oe;
	always_ff @(negedge sck_i or posedge select_n_line_i)
	begin
		if (select_n_line_i)
			oe <= 1'b0; // RULE23
		else
			oe <= drive && (phase == acspi_pkg::ACSPI_PH_DATA); // RULE7
	end

	assign miso_o = miso;
	assign miso_oe_o = oe && !select_n_line_i; // RULE23
	assign lk.cmd_tgl = tgl;
	assign lk.cmd_code = code;
endmodule : acspi_serial

// File: bench/acspi_props.sv
// concurrent checks on the accelerometer spi port pins
`timescale 1ns/1ps
`include "acspi_cfg.svh"
module acspi_props
#(
	parameter int RELOAD_CYC = `ACSPI_RELOAD_CYC
)
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic sck_i,
	input wire logic select_n_line_i,
	input wire logic mosi_i,
	input wire logic miso_oe_o,
	input wire logic pump_x_o,
	input wire logic pump_y_o
);
	logic [4:0] n_rise;
	logic [7:0] cmd;
	wire logic is_rd;
	assign is_rd = cmd == `ACSPI_READ_TEMPERATURE_CMD || cmd == `ACSPI_READ_ACCEL_X_CMD
		|| cmd == `ACSPI_READ_ACCEL_Y_CMD;
	// shadow of the command, cleared by deselect like the device's own
	always_ff @(posedge sck_i or posedge select_n_line_i)
	begin
		if (select_n_line_i)
		begin
			n_rise <= 5'h00;
			cmd <= 8'h00;
		end
		else
		begin
			n_rise <= n_rise + 5'h01;
			if (n_rise < 5'h08)
				cmd <= {cmd[6:0], mosi_i};
		end
	end
	////////////////////////////////////////
	a_oe_desel: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		select_n_line_i |-> !miso_oe_o) else $error("miso driven while deselected");
	a_oe_cmd: assert property (@(posedge sck_i) disable iff (select_n_line_i)
		n_rise < 5'h08 |-> !miso_oe_o) else $error("miso driven during command");
	a_oe_answer: assert property (@(posedge sck_i) disable iff (select_n_line_i)
		n_rise == 5'h08 |-> miso_oe_o == is_rd) else $error("answer start wrong");
	a_oe_refuse: assert property (@(posedge sck_i) disable iff (select_n_line_i)
		n_rise > 5'h08 && !is_rd |-> !miso_oe_o) else $error("miso driven after refusal");
	a_oe_stands: assert property (@(posedge sck_i) disable iff (select_n_line_i)
		n_rise > 5'h08 && is_rd |-> miso_oe_o && $stable(miso_oe_o)) else $error("oe dropped");
	a_pump_excl: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!(pump_x_o && pump_y_o)) else $error("both pumps on");
	a_pump_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		select_n_line_i [*5] |=> $stable({pump_x_o, pump_y_o})) else $error("pump moved idle");
	a_reset_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$fell(rst_i) |-> !pump_x_o && !pump_y_o && !miso_oe_o) else $error("not idle at reset");
	c_read: cover property (@(posedge sck_i) n_rise == 5'h12 && miso_oe_o);
	c_stx: cover property (@(posedge ref_clk_i) $rose(pump_x_o));
	c_bad: cover property (@(posedge sck_i) n_rise == 5'h09 && !is_rd);
endmodule : acspi_props
bind acspi_top acspi_props #(.RELOAD_CYC(RELOAD_CYC)) u_acspi_props (.ref_clk_i(ref_clk_i),
	.rst_i(rst_i), .sck_i(sck_i), .select_n_line_i(select_n_line_i), .mosi_i(mosi_i),
	.miso_oe_o(miso_oe_o), .pump_x_o(pump_x_o), .pump_y_o(pump_y_o));

// File: bench/acspi_master.sv
// spi master model driving link clock, select and serial data
`timescale 1ns/1ps
module acspi_master
(
	output logic sck_o,
	output logic sel_n_o,
	output logic mosi_o,
	input wire logic miso_i,
	input wire logic miso_oe_i
);
	logic last = 1'b0;
	initial
	begin
		sck_o = 1'b0;
		sel_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// clock stands still outside frames; undriven miso reads as flipped
	task automatic xfer(input logic [7:0] cmd, input logic [10:0] wr, input int n,
		output logic [10:0] rd, output logic oe_seen, input int pre = 0);
		logic [18:0] sh;
		sh = {cmd, wr};
		rd = 11'h000;
		oe_seen = 1'b0;
		sel_n_o = 1'b0;
		#(pre);
		for (int i = 0; i < 8 + n; i++)
		begin
			mosi_o = sh[18 - i];
			#16 sck_o = 1'b1;
			last = miso_oe_i ? miso_i : ~last;
			if (i >= 8)
			begin
				rd = {rd[9:0], last};
				oe_seen = oe_seen | miso_oe_i;
			end
			#16 sck_o = 1'b0;
		end
		mosi_o = ~mosi_o;
		#16 sel_n_o = 1'b1;
		#16;
	endtask : xfer
endmodule : acspi_master

// File: bench/test_acspi_top.sv
// self-checking bench for the accelerometer spi command port
`timescale 1ns/1ps
`include "acspi_cfg.svh"
module test_acspi_top;
	localparam int RELOAD = 20;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [10:0] adc_x_i = 11'h5A3;
	logic [10:0] adc_y_i = 11'h2B6;
	logic [7:0] adc_temp_i = 8'hC5;
	logic sck, sel_n, mosi, miso, miso_oe, pump_x, pump_y, seen;
	logic [10:0] rd;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	acspi_top #(.RELOAD_CYC(RELOAD)) u_acspi_top (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.sck_i(sck), .select_n_line_i(sel_n), .mosi_i(mosi), .adc_x_i(adc_x_i),
		.adc_y_i(adc_y_i), .adc_temp_i(adc_temp_i), .miso_o(miso), .miso_oe_o(miso_oe),
		.pump_x_o(pump_x), .pump_y_o(pump_y));
	acspi_master u_acspi_master (.sck_o(sck), .sel_n_o(sel_n), .mosi_o(mosi),
		.miso_i(miso), .miso_oe_i(miso_oe));
	initial
	begin
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_fail++;
			report_and_stop();
		end
	end
	////////////////////////////////////////
	task automatic report_and_stop();
		if (n_fail == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#5;
	endtask : tick
	task automatic rd_chk(input string what, input logic [7:0] c, input logic [10:0] wr,
		input logic [10:0] exp);
		tick(RELOAD + 5);
		u_acspi_master.xfer(c, wr, 11, rd, seen);
		chk(what, exp, rd);
	endtask : rd_chk
	////////////////////////////////////////
	task automatic t_reads();
		rd_chk("accel x", `ACSPI_READ_ACCEL_X_CMD, 11'h000, 11'h5A3);
		rd_chk("accel y", `ACSPI_READ_ACCEL_Y_CMD, 11'h000, 11'h2B6);
		rd_chk("temp", `ACSPI_READ_TEMPERATURE_CMD, 11'h7FF, {8'hC5, 3'h0});
	endtask : t_reads
	// data changes mid-frame must not reach the frozen register
	task automatic t_freeze();
		tick(RELOAD + 5);
		fork
			u_acspi_master.xfer(`ACSPI_READ_ACCEL_X_CMD, 11'h000, 11, rd, seen, 4000);
			#1000 adc_x_i = 11'h1C7;
		join
		chk("frozen x", 11'h5A3, rd);
		rd_chk("new x", `ACSPI_READ_ACCEL_X_CMD, 11'h000, 11'h1C7);
	endtask : t_freeze
	task automatic t_bad();
		u_acspi_master.xfer(8'h55, 11'h7FF, 11, rd, seen);
		chk("refused oe", 11'h000, 11'(seen));
		rd_chk("x after refusal", `ACSPI_READ_ACCEL_X_CMD, 11'h000, 11'h1C7);
	endtask : t_bad
	task automatic t_modes();
		logic [7:0] code [4];
		logic [1:0] want [4];
		code = '{`ACSPI_SELFTEST_X_CMD, `ACSPI_NORMAL_RUN_CMD, `ACSPI_SELFTEST_Y_CMD, 8'h00};
		want = '{2'b10, 2'b00, 2'b01, 2'b00};
		for (int i = 0; i < 4; i++)
		begin
			u_acspi_master.xfer(code[i], 11'h000, 0, rd, seen);
			tick(6);
			chk("pumps", 11'(want[i]), 11'({pump_x, pump_y}));
		end
	endtask : t_modes
	initial
	begin
		tick(5);
		rst_i = 1'b0;
		tick(3);
		chk("pumps at reset", 11'h000, 11'({pump_x, pump_y, miso_oe}));
		t_reads();
		t_freeze();
		t_bad();
		t_modes();
		report_and_stop();
	end
endmodule : test_acspi_top
